//--- hdl/crps_params.svh
`ifndef CRPS_PARAMS_SVH
`define CRPS_PARAMS_SVH

`define CRPS_CLK_HZ        50000000
`define CRPS_MS_PER_S      1000
`define CRPS_PG_TIMEOUT_MS 1000

`define CRPS_AW            4
`define CRPS_DW            32
`define CRPS_OFF_CTRL      4'h0
`define CRPS_OFF_STAT      4'h4
`define CRPS_OFF_IRQ       4'h8
`define CRPS_OFF_MASK      4'hc

`define CRPS_CTRL_RUN      0
`define CRPS_CTRL_RETRY    1
`define CRPS_CTRL_RST      1'h0

`define CRPS_NUM_EV        4
`define CRPS_EV_PG_UP      0
`define CRPS_EV_TIMEOUT    1
`define CRPS_EV_PG_LOST    2
`define CRPS_EV_SUP_LOST   3
`define CRPS_EV_RST        4'h0

`define CRPS_NUM_SYNC      6
`define CRPS_S_V5_OK       0
`define CRPS_S_VIN_OK      1
`define CRPS_S_SUSP_N      2
`define CRPS_S_PG          3
`define CRPS_S_S2RAM       4
`define CRPS_S_S2DISK      5

`define CRPS_STAT_W        10

`endif

//--- hdl/crps_pkg.sv
package crps_pkg;

  typedef enum logic [3:0] {
    CRPS_OFF   = 4'h1,
    CRPS_RAMP  = 4'h2,
    CRPS_ON    = 4'h4,
    CRPS_FAULT = 4'h8
  } crps_state_t;

endpackage

//--- hdl/crps_sync3.sv
`timescale 1ns/1ns
module crps_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] agree;

  // a change is taken only once the second and third stage agree
  assign agree = ~(ff2_reg ^ ff3_reg);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      out_reg <= '0;
    end else begin
      ff1_reg <= async_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      out_reg <= (ff2_reg & agree) | (out_reg & ~agree);
    end
  end

  assign sync_o = out_reg;

endmodule

//--- hdl/crps_timer.sv
`timescale 1ns/1ns
module crps_timer #(
  parameter int CYCLES = 50000000
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      expired_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // counter parks at the limit so expiry stays a level until run drops
  assign expired_o = (cnt_reg == LIMIT);
  assign cnt_next  = !run_i ? '0 : (expired_o ? cnt_reg : cnt_reg + CW'(1));

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

//--- hdl/crps_ctrl.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "crps_params.svh"

// Operation
// R1: the module runs its core regulator exactly while regulator_enable is high.
// R2: regulator_enable is derived from the suspend plane control so the regulator drops in suspend.
// R3: regulator_enable rises only when the switched 5 V and input supply monitors both report good.
// R4: the module raises regulator_power_good once the core supply is at target and stable.
// R5: platform_power_ok is issued only while regulator_power_good is seen high.
// R6: if power-good is not seen within 1 s of enabling, regulator_enable is withdrawn.
// R7: power-good decides which power inputs are applied to the module.
// R8: the cache supply plane is off during suspend-to-RAM and suspend-to-disk.
// R9: the suspend plane control removes the processor, cache, bridge and regulator planes.
// R10: the module holds power-good low while regulator_enable is low.
module crps_ctrl #(
  parameter int TIMEOUT_CYCLES = `CRPS_PG_TIMEOUT_MS * (`CRPS_CLK_HZ / `CRPS_MS_PER_S)
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic [`CRPS_AW-1:0] paddr_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [`CRPS_DW-1:0] pwdata_i,
  output logic      [`CRPS_DW-1:0] prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  output logic                     irq_o,
  input  wire logic                switched_5v_ok_i,
  input  wire logic                input_supply_ok_i,
  input  wire logic                suspend_plane_control_n_i,
  input  wire logic                suspend_to_ram_i,
  input  wire logic                suspend_to_disk_i,
  input  wire logic                regulator_power_good_i,
  output logic                     regulator_enable_o,
  output logic                     platform_power_ok_o,
  output logic                     core_input_plane_en_o,
  output logic                     cache_supply_en_o
);

  function automatic logic addr_is(input logic [`CRPS_AW-1:0] a,
                                   input logic [`CRPS_AW-1:0] off);
    addr_is = (a == off);
  endfunction

  // pin monitors, each through the three-stage synchroniser
  logic [`CRPS_NUM_SYNC-1:0] pins_raw;
  logic [`CRPS_NUM_SYNC-1:0] pins_s;

  assign pins_raw[`CRPS_S_V5_OK]  = switched_5v_ok_i;
  assign pins_raw[`CRPS_S_VIN_OK] = input_supply_ok_i;
  assign pins_raw[`CRPS_S_SUSP_N] = suspend_plane_control_n_i;
  assign pins_raw[`CRPS_S_PG]     = regulator_power_good_i;
  assign pins_raw[`CRPS_S_S2RAM]  = suspend_to_ram_i;
  assign pins_raw[`CRPS_S_S2DISK] = suspend_to_disk_i;

  crps_sync3 #(
    .WIDTH (`CRPS_NUM_SYNC)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (pins_raw),
    .sync_o     (pins_s)
  );

  logic v5_ok_s;
  logic vin_ok_s;
  logic susp_n_s;
  logic pg_s;
  logic s2ram_s;
  logic s2disk_s;

  assign v5_ok_s  = pins_s[`CRPS_S_V5_OK];
  assign vin_ok_s = pins_s[`CRPS_S_VIN_OK];
  assign susp_n_s = pins_s[`CRPS_S_SUSP_N];
  assign pg_s     = pins_s[`CRPS_S_PG];
  assign s2ram_s  = pins_s[`CRPS_S_S2RAM];
  assign s2disk_s = pins_s[`CRPS_S_S2DISK];

  // APB slave: zero wait states, error on unmapped offsets
  logic                     setup_ph;
  logic                     access_ph;
  logic                     hit;
  logic                     wr_ctrl;
  logic                     wr_irq;
  logic                     wr_mask;
  logic [`CRPS_DW-1:0]      rd_mux;
  logic [`CRPS_DW-1:0]      prdata_reg;
  logic [`CRPS_DW-1:0]      prdata_next;

  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign hit       = addr_is(paddr_i, `CRPS_OFF_CTRL) | addr_is(paddr_i, `CRPS_OFF_STAT) |
                     addr_is(paddr_i, `CRPS_OFF_IRQ)  | addr_is(paddr_i, `CRPS_OFF_MASK);
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph & ~hit;
  assign wr_ctrl   = access_ph & pwrite_i & addr_is(paddr_i, `CRPS_OFF_CTRL);
  assign wr_irq    = access_ph & pwrite_i & addr_is(paddr_i, `CRPS_OFF_IRQ);
  assign wr_mask   = access_ph & pwrite_i & addr_is(paddr_i, `CRPS_OFF_MASK);

  // control: run level and a write-one retry pulse that leaves the fault state
  logic run_reg;
  logic run_next;
  logic retry;

  assign run_next = wr_ctrl ? pwdata_i[`CRPS_CTRL_RUN] : run_reg;
  assign retry    = wr_ctrl & pwdata_i[`CRPS_CTRL_RETRY];

  // sequencing
  crps_pkg::crps_state_t state_reg;
  crps_pkg::crps_state_t state_next;
  logic                  supplies_ok;
  logic                  go;
  logic                  tmr_exp;
  logic                  in_ramp;
  logic                  in_on;

  assign supplies_ok = v5_ok_s & vin_ok_s; // R3
  assign go          = run_reg & susp_n_s & supplies_ok; // R2 R9
  assign in_ramp     = (state_reg == crps_pkg::CRPS_RAMP);
  assign in_on       = (state_reg == crps_pkg::CRPS_ON);

  crps_timer #(
    .CYCLES (TIMEOUT_CYCLES)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .run_i      (in_ramp),
    .expired_o  (tmr_exp)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      crps_pkg::CRPS_OFF: begin
        if (go) begin
          state_next = crps_pkg::CRPS_RAMP; // R3
        end
      end
      crps_pkg::CRPS_RAMP: begin
        if (!go) begin
          state_next = crps_pkg::CRPS_OFF;
        end else if (pg_s) begin
          state_next = crps_pkg::CRPS_ON; // R4
        end else if (tmr_exp) begin
          state_next = crps_pkg::CRPS_FAULT; // R6
        end
      end
      crps_pkg::CRPS_ON: begin
        if (!go) begin
          state_next = crps_pkg::CRPS_OFF;
        end else if (!pg_s) begin
          state_next = crps_pkg::CRPS_FAULT;
        end
      end
      crps_pkg::CRPS_FAULT: begin
        // stays off until software asks again, so a dead regulator is not hammered
        if (retry || !run_reg) begin
          state_next = crps_pkg::CRPS_OFF;
        end
      end
      default: begin
        state_next = crps_pkg::CRPS_OFF;
      end
    endcase
  end

  // events
  logic [`CRPS_NUM_EV-1:0] ev;

  assign ev[`CRPS_EV_PG_UP]    = in_ramp & go & pg_s;
  assign ev[`CRPS_EV_TIMEOUT]  = in_ramp & go & ~pg_s & tmr_exp;
  assign ev[`CRPS_EV_PG_LOST]  = in_on & go & ~pg_s;
  assign ev[`CRPS_EV_SUP_LOST] = (in_ramp | in_on) & run_reg & susp_n_s & ~supplies_ok;

  logic [`CRPS_NUM_EV-1:0] irq_stat_reg;
  logic [`CRPS_NUM_EV-1:0] irq_stat_next;
  logic [`CRPS_NUM_EV-1:0] irq_mask_reg;
  logic [`CRPS_NUM_EV-1:0] irq_mask_next;
  logic [`CRPS_NUM_EV-1:0] irq_clr;

  // a new event beats a write-one clear in the same cycle
  assign irq_clr       = wr_irq ? pwdata_i[`CRPS_NUM_EV-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | ev;
  assign irq_mask_next = wr_mask ? pwdata_i[`CRPS_NUM_EV-1:0] : irq_mask_reg;
  assign irq_o         = |(irq_stat_reg & irq_mask_reg);

  // pin outputs
  logic power_ok_reg;
  logic power_ok_next;
  logic cache_en_reg;
  logic cache_en_next;

  // power-ok only while power-good was seen a cycle earlier, dropped one clock after its loss
  assign power_ok_next = (state_next == crps_pkg::CRPS_ON) & pg_s; // R5
  assign cache_en_next = susp_n_s & ~(s2ram_s | s2disk_s); // R8 R9

  assign regulator_enable_o    = in_ramp | in_on; // R1
  assign core_input_plane_en_o = in_on; // R7
  assign platform_power_ok_o   = power_ok_reg;
  assign cache_supply_en_o     = cache_en_reg;

  // read data is captured in the setup cycle and stands through the access cycle
  logic [`CRPS_STAT_W-1:0] status;

  assign status = {power_ok_reg, regulator_enable_o, susp_n_s, vin_ok_s, v5_ok_s, pg_s, state_reg};
  assign rd_mux = addr_is(paddr_i, `CRPS_OFF_CTRL) ? `CRPS_DW'(run_reg) :
                  addr_is(paddr_i, `CRPS_OFF_STAT) ? `CRPS_DW'(status) :
                  addr_is(paddr_i, `CRPS_OFF_IRQ)  ? `CRPS_DW'(irq_stat_reg) :
                  addr_is(paddr_i, `CRPS_OFF_MASK) ? `CRPS_DW'(irq_mask_reg) : '0;
  assign prdata_next = (setup_ph & ~pwrite_i) ? rd_mux : prdata_reg;
  assign prdata_o    = prdata_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg    <= crps_pkg::CRPS_OFF;
      run_reg      <= `CRPS_CTRL_RST;
      irq_stat_reg <= `CRPS_EV_RST;
      irq_mask_reg <= `CRPS_EV_RST;
      power_ok_reg <= 1'b0;
      cache_en_reg <= 1'b0;
      prdata_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      run_reg      <= run_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      power_ok_reg <= power_ok_next;
      cache_en_reg <= cache_en_next;
      prdata_reg   <= prdata_next;
    end
  end

  a_en_after_supply: // R3
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(regulator_enable_o) |-> $past(v5_ok_s) && $past(vin_ok_s))
    else $error("regulator enabled without good supplies");

  a_en_follows_susp: // R2
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      !susp_n_s |=> !regulator_enable_o)
    else $error("regulator enable held during suspend");

  a_pok_needs_pg: // R5
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      platform_power_ok_o |-> $past(pg_s) && regulator_enable_o)
    else $error("power ok without power good");

  a_pok_drops_fast: // R5
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(pg_s) && platform_power_ok_o |=> !platform_power_ok_o)
    else $error("power ok held after power good loss");

  a_timeout_drop: // R6
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      in_ramp && go && tmr_exp && !pg_s ##1 !pg_s |-> !regulator_enable_o [*2])
    else $error("regulator enable not withdrawn on timeout");

  a_inputs_by_pg: // R7
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(core_input_plane_en_o) |-> $past(pg_s) && regulator_enable_o)
    else $error("module inputs applied without power good");

  a_cache_off_susp: // R8
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s2ram_s || s2disk_s) |=> !cache_supply_en_o)
    else $error("cache supply on in suspend to ram or disk");

  a_planes_susp: // R9
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      !susp_n_s |=> !cache_supply_en_o && !core_input_plane_en_o && !platform_power_ok_o)
    else $error("planes left on under suspend control");

  // sequencing and event record checks
  a_supply_loss_drop: // R3
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      !supplies_ok |=> !regulator_enable_o)
    else $error("regulator enable held after supply loss");

  a_en_rise_awake: // R2
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(regulator_enable_o) |-> $past(susp_n_s) && $past(run_reg))
    else $error("regulator enabled in suspend or while stopped");

  a_run_gates_en:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run_reg |=> !regulator_enable_o)
    else $error("regulator enable held while run is clear");

  a_fault_holds: // R6
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_reg == crps_pkg::CRPS_FAULT) && !retry && run_reg |=>
        (state_reg == crps_pkg::CRPS_FAULT) && !regulator_enable_o)
    else $error("fault state left without a retry");

  a_pok_only_on: // R5
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      platform_power_ok_o |-> in_on)
    else $error("power ok outside the on state");

  a_cache_on_awake: // R8
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      susp_n_s && !s2ram_s && !s2disk_s |=> cache_supply_en_o)
    else $error("cache supply off while awake");

  a_pg_up_logged:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      in_ramp && go && pg_s |=> irq_stat_reg[`CRPS_EV_PG_UP])
    else $error("power good event not recorded");

  a_timeout_logged: // R6
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      in_ramp && go && !pg_s && tmr_exp |=> irq_stat_reg[`CRPS_EV_TIMEOUT])
    else $error("timeout event not recorded");

  a_pg_lost_logged:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      in_on && go && !pg_s |=> irq_stat_reg[`CRPS_EV_PG_LOST])
    else $error("power good loss not recorded");

  a_stat_sticky:
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> ($past(irq_stat_reg) & ~$past(irq_clr) & ~irq_stat_reg) == '0)
    else $error("status bit lost without a clear");

  // helper: cycles the enable has stood without synchronised power-good
  logic [31:0] pg_wait_reg;
  logic [31:0] pg_wait_next;

  assign pg_wait_next = (regulator_enable_o & ~pg_s) ? pg_wait_reg + 32'h1 : '0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pg_wait_reg <= '0;
    end else begin
      pg_wait_reg <= pg_wait_next;
    end
  end

  a_pg_wait_bound: // R6
    assert property (@(posedge core_clk_i) disable iff (rst_i)
      pg_wait_reg <= 32'(TIMEOUT_CYCLES) + 32'h1)
    else $error("regulator enable held too long without power good");

endmodule

//--- tb/crps_reg_model.sv
`timescale 1ns/1ns
module crps_reg_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       regulator_enable_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       stall_i,
  input  wire logic       drop_i,
  output logic            regulator_power_good_o
);
  logic [7:0] cnt_reg;

  // settle time restarts whenever the enable goes away
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !regulator_enable_i) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != delay_i) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // stall_i: never settles, drop_i: loses regulation; both only when the bench asks
  assign regulator_power_good_o = regulator_enable_i && cnt_reg == delay_i && !stall_i && !drop_i;
endmodule

//--- tb/core_regulator_power_sequencing_tb.sv
`timescale 1ns/1ns
module core_regulator_power_sequencing_tb;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        pen = 1'h0;
  logic        pwr = 1'h0;
  logic [3:0]  paddr = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, perr, irq, en, pok, core_en, cache_en, pg, err;
  logic        v5 = 1'h1;
  logic        vin = 1'h1;
  logic        susp_n = 1'h1;
  logic        s2ram = 1'h0;
  logic        s2disk = 1'h0;
  logic        stall = 1'h0;
  logic        drop = 1'h0;
  logic [2:0]  tbl [3] = '{3'h5, 3'h6, 3'h0};
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  wire  [4:0]  obs = {irq, cache_en, core_en, pok, en};

  always #10 clk = ~clk;

  crps_ctrl #(.TIMEOUT_CYCLES(50)) dut (
    .core_clk_i(clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .irq_o(irq), .switched_5v_ok_i(v5), .input_supply_ok_i(vin), .suspend_plane_control_n_i(susp_n),
    .suspend_to_ram_i(s2ram), .suspend_to_disk_i(s2disk), .regulator_power_good_i(pg),
    .regulator_enable_o(en), .platform_power_ok_o(pok), .core_input_plane_en_o(core_en),
    .cache_supply_en_o(cache_en)
  );

  crps_reg_model model (
    .core_clk_i(clk), .rst_i(rst), .regulator_enable_i(en), .delay_i(8'h08),
    .stall_i(stall), .drop_i(drop), .regulator_power_good_o(pg)
  );

  task automatic close_out();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // whole run needs a few hundred cycles; this only catches a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  // waits for pready as long as it takes; a hang is ended by the cycle ceiling
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(exp, rd);
  endtask

  task automatic wait_bit(input int b, input logic v);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (obs[b] !== v && n < 400);
    if (n >= 400) begin
      n_fail++;
      $display("ERROR %0t: wait timed out", $time);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (8) @(posedge clk);
    rd_chk(4'h4, 32'h0e1);
    chk(32'h0, en);
    v5 <= 1'h0;
    apb(1'h1, 4'hc, 32'hf);
    apb(1'h1, 4'h0, 32'h1);
    rd_chk(4'h0, 32'h1);
    repeat (10) @(negedge clk);
    chk(32'h0, en);
    @(posedge clk);
    v5 <= 1'h1;
    wait_bit(0, 1'h1);
    chk(32'h0, pok);
    wait_bit(1, 1'h1);
    chk(32'h1, pg);
    chk(32'h1, core_en);
    rd_chk(4'h4, 32'h3f4);
    rd_chk(4'h8, 32'h1);
    chk(32'h1, irq);
    apb(1'h1, 4'h8, 32'h1);
    rd_chk(4'h8, 32'h0);
    chk(32'h0, irq);
    // ram suspend, disk suspend, then plane suspend
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {susp_n, s2disk, s2ram} <= tbl[i];
      repeat (8) @(negedge clk);
      chk(32'h0, cache_en);
      chk(i < 2, en);
      chk(i < 2, pok);
      @(posedge clk);
      {susp_n, s2disk, s2ram} <= 3'h4;
      repeat (8) @(negedge clk);
      wait_bit(1, 1'h1);
      chk(32'h1, cache_en);
    end
    // input supply lost while on: enable withdrawn, then a fresh ramp
    @(posedge clk);
    vin <= 1'h0;
    wait_bit(0, 1'h0);
    chk(32'h0, pok);
    chk(32'h0, core_en);
    @(posedge clk);
    vin <= 1'h1;
    wait_bit(1, 1'h1);
    rd_chk(4'h8, 32'h9);
    apb(1'h1, 4'h8, 32'hf);
    apb(1'h1, 4'hc, 32'h3);
    rd_chk(4'hc, 32'h3);
    drop <= 1'h1;
    wait_bit(1, 1'h0);
    chk(32'h0, core_en);
    rd_chk(4'h4, 32'h0e8);
    chk(32'h0, irq);
    rd_chk(4'h8, 32'h4);
    apb(1'h1, 4'hc, 32'hf);
    @(negedge clk);
    chk(32'h1, irq);
    apb(1'h1, 4'h8, 32'hf);
    drop <= 1'h0;
    repeat (10) @(negedge clk);
    chk(32'h0, en);
    @(posedge clk);
    stall <= 1'h1;
    apb(1'h1, 4'h0, 32'h3);
    wait_bit(0, 1'h1);
    wait_bit(0, 1'h0);
    chk(32'h1, n >= 49 && n <= 53);
    chk(32'h0, pok);
    rd_chk(4'h8, 32'h2);
    apb(1'h1, 4'h8, 32'hf);
    stall <= 1'h0;
    apb(1'h1, 4'h0, 32'h3);
    rd_chk(4'h0, 32'h1);
    wait_bit(1, 1'h1);
    chk(32'h1, pg);
    apb(1'h1, 4'h0, 32'h0);
    wait_bit(0, 1'h0);
    chk(32'h0, pok);
    rd_chk(4'h2, 32'h0);
    chk(32'h1, err);
    close_out();
  end
endmodule
